// ===== hw/esb_pkg.sv
/*
 * Shared constants and types of the external bus sharing block.
 * Assumes a single 40 MHz system clock and a 16-bit external bus.
 */
package esb_pkg;
	// ==========================================================
	// Bus geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int IO_PORT_W = 4;
	localparam int SIZE_W = 8;
	// Global size register reset value: no global area defined
	localparam logic [SIZE_W-1:0] SIZE_RST = 8'h00;
	// Smallest global area in words, one per value of the unmasked low address byte
	localparam int GLOBAL_MIN_WORDS = 256;
	localparam int GLOBAL_MAX_WORDS = 32768;
	// ==========================================================
	// Clock and lock-step phase counting
	localparam int CLK_PERIOD_NS = 25;
	localparam int PHASES = 4;
	localparam int PHASE_W = 2;
	localparam logic [PHASE_W-1:0] PHASE_RST = 2'h0;
	localparam logic [PHASE_W-1:0] PHASE_LAST = 2'h3;
	// Pin synchroniser depth
	localparam int SYNC_STAGES = 3;
	// Pins passed through the synchroniser, bit positions
	localparam int PIN_YIELD = 0;
	localparam int PIN_READY = 1;
	localparam int PIN_RESET = 2;
	localparam int PIN_SYNC = 3;
	localparam int PIN_COUNT = 4;
	localparam logic [PIN_COUNT-1:0] PIN_IDLE = 4'hd;
	// ==========================================================
	// Bus cycle sequencer, Gray coded along idle-access-wait
	typedef enum logic [1:0] {
		ESB_IDLE = 2'h0,
		ESB_ACCESS = 2'h1,
		ESB_WAIT = 2'h3,
		ESB_YIELDED = 2'h2
	} esb_state_t;
endpackage

// ===== hw/esb_pins_if.sv
/*
 * Carrier between the pin synchroniser and the bus sequencer.
 * Assumes raw levels arrive asynchronously from outside pins.
 */
`timescale 1ns/100ps
interface esb_pins_if #(
	parameter int N = 4
);
	logic [N-1:0] raw;
	logic [N-1:0] clean;
	// ==========================================================
	// Synchroniser side and consumer side
	modport filt (input raw, output clean);
	modport user (output raw, input clean);
endinterface

// ===== hw/esb_pin_sync.sv
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes inputs are asynchronous to clk; clean bits change only
 * once the second and third stages agree.
 */
`timescale 1ns/100ps
module esb_pin_sync #(
	parameter int N = 4,
	parameter logic [N-1:0] IDLE = '0
) (
	input wire logic clk,
	input wire logic rst,
	esb_pins_if.filt pins
);
	logic [N-1:0] s1_q, s1_d;
	logic [N-1:0] s2_q, s2_d;
	logic [N-1:0] s3_q, s3_d;
	logic [N-1:0] out_q, out_d;

	// Elaboration check: at least one pin to filter
	if (N < 1) begin : g_bad_n
		$error("esb_pin_sync needs at least one pin");
	end

	// ==========================================================
	// Stage shifting and agreement, one filter per pin
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_pin
			// First stage is read only by the second
			always_comb begin
				s1_d[g] = pins.raw[g];
				s2_d[g] = s1_q[g];
				s3_d[g] = s2_q[g];
				out_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : out_q[g];
			end
		end
	endgenerate

	// Registers, preset to the idle pin levels
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= IDLE;
			s2_q <= IDLE;
			s3_q <= IDLE;
			out_q <= IDLE;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			out_q <= out_d;
		end
	end

	assign pins.clean = out_q;
endmodule

// ===== hw/esb_bus_share.sv
/*
 * External bus sharing logic: bus yield to an outside master, global
 * area requests with ready as grant, parallel I/O select, lock-step
 * phase alignment.
 * Assumes a core-side requester that holds its request until done,
 * and outside logic that resolves the pin levels from the enables.
 */
// Function
// - Float address, data, control while yielded, entered only between bus cycles
// - Acknowledge yield after buses are released
// - Size register sets global area, 256..32K
// - Assert global request with the strobe of each global access
// - Wait states until ready grants the bus
// - Global access never halts a processor
// - I/O uses low address nibble, select low
// - Sync input aligns phases for lock-step
`timescale 1ns/100ps
module esb_bus_share #(
	parameter int ADDR_W = esb_pkg::ADDR_W,
	parameter int DATA_W = esb_pkg::DATA_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic core_req,
	input wire logic core_write,
	input wire logic core_io,
	input wire logic [ADDR_W-1:0] core_addr,
	input wire logic [DATA_W-1:0] core_wdata,
	output logic core_done,
	output logic [DATA_W-1:0] core_rdata,
	output logic core_halted,
	output logic core_reset,
	input wire logic size_load,
	input wire logic [esb_pkg::SIZE_W-1:0] size_value,
	output logic [esb_pkg::SIZE_W-1:0] global_size_register,
	input wire logic bus_yield_req_n,
	output logic bus_yield_ack_n,
	input wire logic ready,
	input wire logic reset_input_n,
	input wire logic sync_n,
	output logic [esb_pkg::PHASE_W-1:0] phase,
	output logic [ADDR_W-1:0] addr_o,
	output logic addr_oe,
	input wire logic [DATA_W-1:0] data_i,
	output logic [DATA_W-1:0] data_o,
	output logic data_oe,
	output logic strobe_n,
	output logic strobe_oe,
	output logic read_write,
	output logic read_write_oe,
	output logic global_bus_request_n,
	output logic global_bus_request_oe,
	output logic io_space_select_n,
	output logic io_space_select_oe
);
	// Elaboration check: the I/O and global decode assume a 16-bit address
	if (ADDR_W != esb_pkg::ADDR_W || DATA_W < 1) begin : g_bad_width
		$error("esb_bus_share supports a 16-bit address only");
	end

	// ==========================================================
	// Pin synchronisers
	esb_pins_if #(.N(esb_pkg::PIN_COUNT)) pins ();

	assign pins.raw[esb_pkg::PIN_YIELD] = bus_yield_req_n;
	assign pins.raw[esb_pkg::PIN_READY] = ready;
	assign pins.raw[esb_pkg::PIN_RESET] = reset_input_n;
	assign pins.raw[esb_pkg::PIN_SYNC] = sync_n;

	esb_pin_sync #(
		.N(esb_pkg::PIN_COUNT),
		.IDLE(esb_pkg::PIN_IDLE)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.pins(pins)
	);

	logic yield_req;
	logic ready_s;
	logic reset_req;
	logic sync_low;
	assign yield_req = ~pins.clean[esb_pkg::PIN_YIELD];
	assign ready_s = pins.clean[esb_pkg::PIN_READY];
	assign reset_req = ~pins.clean[esb_pkg::PIN_RESET];
	assign sync_low = ~pins.clean[esb_pkg::PIN_SYNC];

	// ==========================================================
	// Global area decode: a set mask bit must match in the address
	function automatic logic is_global(input logic [ADDR_W-1:0] a,
			input logic [esb_pkg::SIZE_W-1:0] m);
		is_global = (m != '0) && ((a[ADDR_W-1 -: esb_pkg::SIZE_W] & m) == m);
	endfunction

	logic [esb_pkg::SIZE_W-1:0] size_q, size_d;

	// Size register; mask 8'h80 gives 32K words, 8'hff gives 256
	always_comb begin
		size_d = size_q;
		if (size_load) begin
			size_d = size_value;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			size_q <= esb_pkg::SIZE_RST;
		end else begin
			size_q <= size_d;
		end
	end

	assign global_size_register = size_q;

	// ==========================================================
	// Bus cycle sequencer
	esb_pkg::esb_state_t state_q, state_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic write_q, write_d;
	logic io_q, io_d;
	logic glob_q, glob_d;
	logic done_q, done_d;
	logic ack_n_q, ack_n_d;
	// Wait cycles spent before the synchronised ready may be trusted
	localparam logic [1:0] READY_HOLD = 2'(esb_pkg::SYNC_STAGES - 1);
	logic [1:0] hold_q, hold_d;

	// Next state; a yield is honoured only between bus cycles so that
	// a transfer is never cut in half on the shared pins
	always_comb begin
		state_d = state_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		write_d = write_q;
		io_d = io_q;
		glob_d = glob_q;
		done_d = 1'b0;
		hold_d = hold_q;
		unique case (state_q)
			esb_pkg::ESB_IDLE: begin
				if (yield_req) begin
					state_d = esb_pkg::ESB_YIELDED;
				end else if (core_req && !core_done && !reset_req) begin
					state_d = esb_pkg::ESB_ACCESS;
					hold_d = '0;
					write_d = core_write;
					io_d = core_io;
					wdata_d = core_wdata;
					if (core_io) begin
						// Upper bits low, port number in the low nibble
						addr_d = {{(ADDR_W-esb_pkg::IO_PORT_W){1'b0}},
							core_addr[esb_pkg::IO_PORT_W-1:0]};
						glob_d = 1'b0;
					end else begin
						addr_d = core_addr;
						glob_d = is_global(core_addr, size_q);
					end
				end
			end
			esb_pkg::ESB_ACCESS: begin
				state_d = esb_pkg::ESB_WAIT;
			end
			esb_pkg::ESB_WAIT: begin
				// Wait states last until ready grants; no halt involved. A grant
				// of the previous cycle may still sit in the synchroniser, so
				// ready is looked at only once that has flushed out
				if (hold_q != READY_HOLD) begin
					hold_d = hold_q + 2'h1;
				end else if (ready_s) begin
					state_d = esb_pkg::ESB_IDLE;
					done_d = 1'b1;
					if (!write_q) begin
						rdata_d = data_i;
					end
				end
			end
			esb_pkg::ESB_YIELDED: begin
				if (!yield_req) begin
					state_d = esb_pkg::ESB_IDLE;
				end
			end
		endcase
		// Acknowledge follows the release by one cycle, and rises in the cycle drive returns
		ack_n_d = !(state_q == esb_pkg::ESB_YIELDED && yield_req);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= esb_pkg::ESB_IDLE;
			addr_q <= '0;
			wdata_q <= '0;
			rdata_q <= '0;
			write_q <= 1'b0;
			io_q <= 1'b0;
			glob_q <= 1'b0;
			done_q <= 1'b0;
			ack_n_q <= 1'b1;
			hold_q <= '0;
		end else begin
			state_q <= state_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			write_q <= write_d;
			io_q <= io_d;
			glob_q <= glob_d;
			done_q <= done_d;
			ack_n_q <= ack_n_d;
			hold_q <= hold_d;
		end
	end

	// ==========================================================
	// Lock-step phase: sync low holds phase zero, release starts count
	logic [esb_pkg::PHASE_W-1:0] phase_q, phase_d;

	always_comb begin
		if (sync_low) begin
			phase_d = esb_pkg::PHASE_RST;
		end else if (phase_q == esb_pkg::PHASE_LAST) begin
			phase_d = esb_pkg::PHASE_RST;
		end else begin
			phase_d = phase_q + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			phase_q <= esb_pkg::PHASE_RST;
		end else begin
			phase_q <= phase_d;
		end
	end

	assign phase = phase_q;

	// ==========================================================
	// Pin drive; every bus output floats while yielded
	logic driving;
	logic cycle;
	assign driving = (state_q != esb_pkg::ESB_YIELDED);
	assign cycle = (state_q == esb_pkg::ESB_ACCESS) || (state_q == esb_pkg::ESB_WAIT);

	assign addr_o = addr_q;
	assign addr_oe = driving;
	assign data_o = wdata_q;
	assign data_oe = driving && cycle && write_q;
	assign strobe_n = !cycle;
	assign strobe_oe = driving;
	assign read_write = !write_q;
	assign read_write_oe = driving;
	// Request moves with the strobe by riding the same cycle flops
	assign global_bus_request_n = !(cycle && glob_q);
	assign global_bus_request_oe = driving;
	assign io_space_select_n = !(cycle && io_q);
	assign io_space_select_oe = driving;
	assign bus_yield_ack_n = ack_n_q;

	// ==========================================================
	// Core side; the core stalls only for a yield, never for global
	// traffic, and a pin reset with yield lets the master download
	assign core_done = done_q;
	assign core_rdata = rdata_q;
	assign core_halted = (state_q == esb_pkg::ESB_YIELDED);
	assign core_reset = reset_req;
endmodule

// ===== test/esb_asserts.sv
/* Port checker of the bus sharing block.
 Assumes a bind onto esb_bus_share, single clock domain. */
`timescale 1ns/100ps
module esb_asserts #(
	parameter int ADDR_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic core_halted,
	input wire logic size_load,
	input wire logic [esb_pkg::SIZE_W-1:0] size_value,
	input wire logic [esb_pkg::SIZE_W-1:0] global_size_register,
	input wire logic bus_yield_ack_n,
	input wire logic [esb_pkg::PHASE_W-1:0] phase,
	input wire logic [ADDR_W-1:0] addr_o,
	input wire logic addr_oe,
	input wire logic data_oe,
	input wire logic strobe_n,
	input wire logic ready,
	input wire logic global_bus_request_n,
	input wire logic io_space_select_n
);
	// ==========================================================
	// Properties, all on clk with reset as disable
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_yield_float: assert property (!bus_yield_ack_n |-> !addr_oe && !data_oe)
		else $error("bus driven while yielded");
	a_ack_after_float: assert property ($fell(bus_yield_ack_n) |-> $past(!addr_oe))
		else $error("yield acknowledged before release");
	a_release_drive: assert property ($rose(bus_yield_ack_n) |-> ##[0:1] addr_oe)
		else $error("bus not driven after yield end");
	a_size_load: assert property (size_load |=> global_size_register == $past(size_value))
		else $error("size register not loaded");
	a_global_strobe: assert property ($fell(global_bus_request_n) |-> !strobe_n)
		else $error("global request without access");
	// Synchroniser delay: ready must stay low long enough to be seen
	a_wait_ready: assert property ((!strobe_n && !ready) [*6] |=> !strobe_n)
		else $error("access ended without ready");
	a_global_no_halt: assert property (!global_bus_request_n |-> !core_halted)
		else $error("halted during global access");
	a_io_addr: assert property (!io_space_select_n |-> addr_o[ADDR_W-1:4] == '0)
		else $error("upper address not low on port access");
	a_phase_step: assert property (phase != 2'h0 |-> phase == $past(phase) + 2'h1)
		else $error("phase skipped");
	c_yield: cover property ($fell(bus_yield_ack_n));
	c_global: cover property ($fell(global_bus_request_n));
	c_io: cover property ($fell(io_space_select_n));
endmodule

bind esb_bus_share esb_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rst(rst),
	.core_halted(core_halted), .size_load(size_load), .size_value(size_value),
	.global_size_register(global_size_register), .bus_yield_ack_n(bus_yield_ack_n),
	.phase(phase), .addr_o(addr_o), .addr_oe(addr_oe), .data_oe(data_oe),
	.strobe_n(strobe_n), .ready(ready), .global_bus_request_n(global_bus_request_n),
	.io_space_select_n(io_space_select_n));

// ===== test/esb_far_end.sv
/* Outside arbitration and memory model.
 Assumes the device pins are seen directly, no pull resistors. */
`timescale 1ns/100ps
module esb_far_end (
	input wire logic clk,
	input wire logic strobe_n,
	input wire logic read_write,
	input wire logic [15:0] addr_o,
	input wire logic yield_cmd_n,
	input wire logic [3:0] ready_delay,
	input wire logic bus_yield_ack_n,
	output logic master_ready,
	output logic ready,
	output logic bus_yield_req_n,
	output logic [15:0] data_i
);
	logic [3:0] cnt = 4'h0;
	logic [15:0] junk = 16'h0;
	// ==========================================================
	// Grant delay count; junk moves so idle data is never stale
	always @(posedge clk) begin
		cnt <= strobe_n ? 4'h0 : (cnt == 4'hf ? cnt : cnt + 4'h1);
		junk <= junk + 16'h1357;
	end
	assign ready = !strobe_n && cnt >= ready_delay; // Grant
	assign bus_yield_req_n = yield_cmd_n; // Flag driven yield
	// System master is held not ready until the block acknowledges
	assign master_ready = !yield_cmd_n && !bus_yield_ack_n;
	assign data_i = (!strobe_n && read_write) ? ~addr_o : junk;
endmodule

// ===== test/esb_bus_share_tb_top.sv
/* Self-checking bench of the bus sharing block.
 Assumes esb_far_end stands on the pins. */
`timescale 1ns/100ps
module esb_bus_share_tb_top;
	logic clk = 0, rst = 1, req = 0, wr = 0, io = 0, sload = 0, rn = 1, sn = 1, ycmd = 1;
	logic [15:0] addr = 0, wdata = 0, addr_o, data_i, data_o, rdata;
	logic [7:0] sval = 0, gsr;
	logic [3:0] rdly = 0;
	logic [1:0] phase;
	logic done, halted, creset, ack_n, ready, yreq_n, aoe, doe, stb_n, soe, rw, rwoe;
	logic gb_n, gboe, is_n, isoe, mrdy;
	logic [15:0] wseen = 0;
	int slow = 0;
	int n_mismatch = 0, n_tests = 0;
	initial forever #12.5 clk = ~clk;
	esb_bus_share uut (.clk(clk), .rst(rst), .core_req(req), .core_write(wr), .core_io(io),
		.core_addr(addr), .core_wdata(wdata), .core_done(done), .core_rdata(rdata),
		.core_halted(halted), .core_reset(creset), .size_load(sload), .size_value(sval),
		.global_size_register(gsr), .bus_yield_req_n(yreq_n), .bus_yield_ack_n(ack_n),
		.ready(ready), .reset_input_n(rn), .sync_n(sn), .phase(phase), .addr_o(addr_o),
		.addr_oe(aoe), .data_i(data_i), .data_o(data_o), .data_oe(doe), .strobe_n(stb_n),
		.strobe_oe(soe), .read_write(rw), .read_write_oe(rwoe),
		.global_bus_request_n(gb_n), .global_bus_request_oe(gboe),
		.io_space_select_n(is_n), .io_space_select_oe(isoe));
	esb_far_end far (.clk(clk), .strobe_n(stb_n), .read_write(rw), .addr_o(addr_o),
		.yield_cmd_n(ycmd), .ready_delay(rdly), .bus_yield_ack_n(ack_n),
		.master_ready(mrdy), .ready(ready), .bus_yield_req_n(yreq_n), .data_i(data_i));
	// ==========================================================
	// Shared helpers
	task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Inputs move 2 ns after the edge so sampling never races
	task tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task test_done;
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// One core access; request held until done, strobe-time pins recorded
	task acc(input logic w, input logic i, input logic [15:0] a, output logic gb,
			output logic is, output logic [15:0] ao);
		int k;
		req = 1;
		wr = w;
		io = i;
		addr = a;
		wdata = ~a;
		gb = 1;
		is = 1;
		ao = '1;
		slow = 0;
		for (k = 0; k < 60 && done !== 1'b1; k++) begin
			tick(1);
			if (stb_n === 1'b0) begin
				gb &= gb_n;
				is &= is_n;
				ao = addr_o;
				slow++;
				if (doe === 1'b1) wseen = data_o;
			end
		end
		req = 0;
		if (k == 60) begin
			n_mismatch++;
			test_done;
		end
		// Let an edge pass so the next request is a fresh assignment
		tick(1);
	endtask
	// Wait bounded for the acknowledge to reach a level
	task wait_ack(input logic lvl);
		int k;
		for (k = 0; k < 30 && ack_n !== lvl; k++) tick(1);
		chk(ack_n, lvl, "yield ack");
		if (ack_n !== lvl) test_done;
	endtask
	// ==========================================================
	// Scenarios
	task automatic s_global;
		logic [7:0] m [4] = '{8'h80, 8'h80, 8'hff, 8'hff};
		logic [15:0] a [4] = '{16'h8004, 16'h7ffc, 16'hff00, 16'hfe00};
		logic gb, is;
		logic [15:0] ao;
		chk(gsr, 16'h0, "size reset");
		for (int n = 0; n < 4; n++) begin
			sval = m[n];
			sload = 1;
			tick(1);
			sload = 0;
			rdly = n[0] ? 4'h0 : 4'h8;
			chk(gsr, m[n], "size");
			acc(0, 0, a[n], gb, is, ao);
			chk(gb, n[0], "global request");
			chk(rdata, ~a[n], "read data");
			chk(slow > rdly, 1, "wait states");
		end
	endtask
	task s_io;
		logic gb, is;
		logic [15:0] ao;
		acc(1, 1, 16'h1235, gb, is, ao);
		chk(is, 0, "port select");
		chk(ao, 16'h0005, "port address");
		chk(wseen, 16'hedca, "port write data");
	endtask
	task s_yield;
		logic seen;
		int k;
		ycmd = 0;
		rn = 0;
		tick(1);
		chk(mrdy, 0, "master held not ready");
		wait_ack(0);
		chk(mrdy, 1, "master ready after ack");
		chk({aoe, doe, soe, rwoe, gboe, isoe}, 0, "drive enables");
		chk(halted, 1, "halted");
		chk(creset, 1, "core reset");
		// A read posted while yielded must stay pending, then run
		rn = 1;
		wr = 0;
		io = 0;
		addr = 16'h0042;
		req = 1;
		seen = 0;
		repeat (10) begin
			tick(1);
			seen |= done;
		end
		chk(seen, 0, "done while yielded");
		ycmd = 1;
		wait_ack(1);
		chk(mrdy, 0, "master ready dropped");
		tick(1);
		chk(aoe, 1, "address drive back");
		for (k = 0; k < 60 && done !== 1'b1; k++) tick(1);
		req = 0;
		chk(done, 1, "pending read done");
		chk(rdata, ~16'h0042, "read after yield");
		if (done !== 1'b1) test_done;
		tick(1);
	endtask
	task s_sync;
		logic [1:0] p;
		sn = 0;
		tick(8);
		chk(phase, 0, "phase held");
		sn = 1;
		tick(8);
		p = phase;
		tick(1);
		chk(phase, 2'(p + 2'h1), "phase step");
	endtask
	initial begin
		tick(12);
		rst = 0;
		tick(1);
		s_global;
		s_io;
		s_yield;
		s_sync;
		test_done;
	end
endmodule
